/* pfm_pkg.sv */
// pin mux constants: modes, resets, pin
// positions, routes.
// assumes one bus clock domain.
//
// Contract
// - E5 is gpio, latches mode bit a
// - E6 latches mode bit b at reset rise
// - E5 carries queue tracking output 0
// - E4 may drive the bus clock
// - E3 is low byte strobe when expanded
// - E3 low tags low instruction half
// - E2 is bus read/write when expanded
// - E1 maskable irq input, wakes from stop
// - E0 nonmaskable irq input, wakes from stop
// - H, J7/6/1/0, P7..4 key wakeup inputs
// - spi2 on H7..4, spi1 on H3..0
// - mosi drives when master, listens when slave
// - miso listens when master, drives when slave
// - J7/J6 carry can4 or i2c
// - K7 is emulation chip select when expanded
// - K7 latched into flash map enable in modes 101 and 111
// - flash map reset value follows mode
// - K5..0 carry page address when expanded
// - port M carries can0 and can4 routings
// - M5..2 carry spi0 sck mosi ss miso
// - P7..4 carry pwm7..4 or spi2
package pfm_pkg;

	// operating modes, {c, b, a}
	localparam logic [2:0] MODE_SPECIAL_SINGLE = 3'h0;
	localparam logic [2:0] MODE_EMU_NARROW = 3'h1;
	localparam logic [2:0] MODE_SPECIAL_TEST = 3'h2;
	localparam logic [2:0] MODE_EMU_WIDE = 3'h3;
	localparam logic [2:0] MODE_NORMAL_SINGLE = 3'h4;
	localparam logic [2:0] MODE_NORMAL_NARROW = 3'h5;
	localparam logic [2:0] MODE_PERIPH_TEST = 3'h6;
	localparam logic [2:0] MODE_NORMAL_WIDE = 3'h7;

	// reset values
	localparam logic [2:0] MODE_RESET = 3'h0;
	localparam logic FLASH_MAP_RESET = 1'b1;

	// port e bit positions
	localparam int E_NMI = 0;
	localparam int E_IRQ = 1;
	localparam int E_RW = 2;
	localparam int E_STROBE = 3;
	localparam int E_BUSCLK = 4;
	localparam int E_MODE_A = 5;
	localparam int E_MODE_B = 6;

	// port k fields
	localparam int K_CHIP_SEL = 7;
	localparam int PAGE_W = 6;

	// port j: legal wake bits and can4 / i2c pins
	localparam logic [7:0] J_WAKE_MASK = 8'hc3;
	localparam int J_TX = 7;
	localparam int J_RX = 6;

	// can routing selections
	localparam logic [1:0] CAN_OFF = 2'h0;
	localparam logic [1:0] CAN0_M10 = 2'h1;
	localparam logic [1:0] CAN0_M32 = 2'h2;
	localparam logic [1:0] CAN0_M54 = 2'h3;
	localparam logic [1:0] CAN4_J76 = 2'h1;
	localparam logic [1:0] CAN4_M54 = 2'h2;
	localparam logic [1:0] CAN4_M76 = 2'h3;

	// spi pin positions: within an h nibble, on port m, on port p
	localparam int H_SS = 3;
	localparam int H_SCK = 2;
	localparam int H_MOSI = 1;
	localparam int H_MISO = 0;
	localparam int M_SCK = 5;
	localparam int M_MOSI = 4;
	localparam int M_SS = 3;
	localparam int M_MISO = 2;
	localparam int P_SCK = 7;
	localparam int P_SS = 6;
	localparam int P_MOSI = 5;
	localparam int P_MISO = 4;

	// pwm channels 7..4 sit on p7..4
	localparam int PWM_P_LSB = 4;

	// wake vector {h7..0, j7..0, p7..4}
	localparam int WAKE_W = 20;

	// edge sense of a wake input
	typedef enum logic [0:0] {
		SENSE_FALL = 1'b0,
		SENSE_RISE = 1'b1
	} pfm_sense_type;

endpackage : pfm_pkg

/* pfm_wake_detect.sv */
// key wakeup edge detect, sticky flags.
// assumes pin_sync is two-flop synced; pin_raw is the bare pin.
`timescale 1ns/1ps
module pfm_wake_detect #(
	parameter int WIDTH = 20
) (
	input logic clock,
	input logic reset_n,
	input logic [WIDTH-1:0] pin_raw,
	input logic [WIDTH-1:0] pin_sync,
	input logic [WIDTH-1:0] enable,
	input logic [WIDTH-1:0] rising,
	input logic [WIDTH-1:0] clear,
	output logic [WIDTH-1:0] flags_q,
	output logic wake_async
);

	// refuse an empty vector
	if (WIDTH < 1) begin : g_bad_width
		$error("pfm_wake_detect: WIDTH must be at least 1");
	end

	logic [WIDTH-1:0] prev_q; // last synchronised level
	logic [WIDTH-1:0] hit; // enabled edge this cycle
	logic [WIDTH-1:0] flags_d; // next flag state

	////////////////////////////////////////////////////////////////////////////
	// edge detection per input
	genvar i;
	for (i = 0; i < WIDTH; i++) begin : g_edge
		// sense picks the edge that counts
		assign hit[i] = enable[i] & (rising[i] ? (pin_sync[i] & ~prev_q[i])
			: (~pin_sync[i] & prev_q[i]));
	end

	// a new edge wins over a clear in the same cycle
	assign flags_d = (flags_q & ~clear) | hit;

	// stopped clock: bare level wakes
	assign wake_async = |(enable & ~(pin_raw ^ rising));

	////////////////////////////////////////////////////////////////////////////
	// state
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			// pins idle high; a low reset value would fake a rising edge
			prev_q <= '1;
			flags_q <= '0;
		end
		else
		begin
			prev_q <= pin_sync;
			flags_q <= flags_d;
		end
	end

endmodule : pfm_wake_detect

/* pfm_port_mux.sv */
// pin mux for ports e, h, j, k, m, p,
// with strap latches and key wakeup.
// assumes core inputs on clock; pins async;
// pads resolve each pin from out and oe.
`timescale 1ns/1ps
module pfm_port_mux (
	input logic clock,
	input logic reset_n,
	// pins
	input logic reset_pin_n,
	input logic mode_select_pin_c,
	input logic [7:0] port_e_in,
	output logic [7:0] port_e_out_q,
	output logic [7:0] port_e_oe_q,
	input logic [7:0] port_h_in,
	output logic [7:0] port_h_out_q,
	output logic [7:0] port_h_oe_q,
	input logic [7:0] port_j_in,
	output logic [7:0] port_j_out_q,
	output logic [7:0] port_j_oe_q,
	input logic [7:0] port_k_in,
	output logic [7:0] port_k_out_q,
	output logic [7:0] port_k_oe_q,
	input logic [7:0] port_m_in,
	output logic [7:0] port_m_out_q,
	output logic [7:0] port_m_oe_q,
	input logic [7:0] port_p_in,
	output logic [7:0] port_p_out_q,
	output logic [7:0] port_p_oe_q,
	// general purpose io
	input logic [7:0] gpio_e_out,
	input logic [7:0] gpio_e_dir,
	input logic [7:0] gpio_h_out,
	input logic [7:0] gpio_h_dir,
	input logic [7:0] gpio_j_out,
	input logic [7:0] gpio_j_dir,
	input logic [7:0] gpio_k_out,
	input logic [7:0] gpio_k_dir,
	input logic [7:0] gpio_m_out,
	input logic [7:0] gpio_m_dir,
	input logic [7:0] gpio_p_out,
	input logic [7:0] gpio_p_dir,
	output logic [47:0] gpio_in_q,
	// mode and expanded bus
	output logic mode_select_bit_a_q,
	output logic mode_select_bit_b_q,
	output logic mode_select_bit_c_q,
	output logic flash_map_enable_bit_q,
	output logic expanded_mode_q,
	input logic queue_track_en,
	input logic queue_track_out_0,
	input logic bus_clock_out_en,
	input logic bus_clock_level,
	input logic tag_enable,
	input logic low_byte_strobe_n,
	input logic bus_read_write,
	input logic emulation_chip_select_n,
	input logic [5:0] page_address_out,
	output logic tag_low_half_n_q,
	// interrupts and wakeup
	output logic irq_request_q,
	output logic nonmaskable_irq_q,
	input logic [19:0] key_wake_enable,
	input logic [19:0] key_wake_rising,
	input logic [19:0] key_wake_clear,
	output logic [19:0] key_wake_flags_q,
	output logic key_wake_irq_q,
	output logic wake_async,
	// serial peripheral interfaces 2..0
	input logic [2:0] spi_enable,
	input logic spi2_on_port_p,
	input logic [2:0] spi_master,
	input logic [2:0] spi_sck_out,
	input logic [2:0] spi_ss_out,
	input logic [2:0] spi_ss_oe,
	input logic [2:0] spi_mosi_out,
	input logic [2:0] spi_miso_out,
	output logic [2:0] spi_sck_in_q,
	output logic [2:0] spi_ss_in_q,
	output logic [2:0] spi_mosi_in_q,
	output logic [2:0] spi_miso_in_q,
	// can, i2c, pwm
	input logic [1:0] can0_route,
	input logic [1:0] can4_route,
	input logic can0_transmit_pin,
	input logic can4_transmit_pin,
	output logic can0_receive_pin_q,
	output logic can4_receive_pin_q,
	input logic i2c_enable,
	input logic i2c_scl_out,
	input logic i2c_sda_out,
	output logic i2c_scl_in_q,
	output logic i2c_sda_in_q,
	input logic [3:0] pwm_enable,
	input logic [3:0] pwm_out
);

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [49:0] pin_s1_q; // first stage, read by second only
	logic [49:0] pin_s2_q; // settled pin levels
	logic [7:0] e_s, h_s, j_s, k_s, m_s, p_s; // settled ports
	logic rst_pin_s; // settled reset pin
	logic rst_pin_prev_q; // reset pin one cycle ago
	logic rst_pin_rise; // rising edge of the reset pin

	assign {rst_pin_s, e_s, h_s, j_s, k_s, m_s, p_s} = {pin_s2_q[49], pin_s2_q[47:0]};
	assign rst_pin_rise = rst_pin_s & ~rst_pin_prev_q;

	// two flops on every pin; only the stopped-clock wake path reads bare pins
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			// pins idle high, so no false irq or edge after reset
			pin_s1_q <= {1'b0, 49'h1ffffffffffff};
			pin_s2_q <= {1'b0, 49'h1ffffffffffff};
		end
		else
		begin
			pin_s1_q <= {reset_pin_n, mode_select_pin_c, port_e_in, port_h_in,
				port_j_in, port_k_in, port_m_in, port_p_in};
			pin_s2_q <= pin_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// mode straps and flash map enable
	logic [2:0] mode_q; // {c, b, a}
	logic [2:0] strap_mode; // mode seen on the straps now
	logic strap_flash; // flash enable for that mode
	logic expanded; // external bus active

	// straps read on the settled pins
	assign strap_mode = {pin_s2_q[48], e_s[pfm_pkg::E_MODE_B], e_s[pfm_pkg::E_MODE_A]};

	// mode decides flash; 101 and 111 take k7
	always_comb
	begin
		unique case (strap_mode)
			pfm_pkg::MODE_SPECIAL_SINGLE,
			pfm_pkg::MODE_NORMAL_SINGLE,
			pfm_pkg::MODE_PERIPH_TEST: strap_flash = 1'b1;
			pfm_pkg::MODE_EMU_WIDE,
			pfm_pkg::MODE_EMU_NARROW,
			pfm_pkg::MODE_SPECIAL_TEST: strap_flash = 1'b0;
			default: strap_flash = k_s[pfm_pkg::K_CHIP_SEL];
		endcase
	end

	// every mode with an external bus
	assign expanded = mode_q inside {pfm_pkg::MODE_EMU_NARROW, pfm_pkg::MODE_SPECIAL_TEST,
		pfm_pkg::MODE_EMU_WIDE, pfm_pkg::MODE_NORMAL_NARROW,
		pfm_pkg::MODE_NORMAL_WIDE};

	// latch straps on the reset pin's rising edge
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			rst_pin_prev_q <= 1'b0;
			mode_q <= pfm_pkg::MODE_RESET;
			flash_map_enable_bit_q <= pfm_pkg::FLASH_MAP_RESET;
			expanded_mode_q <= 1'b0;
		end
		else
		begin
			rst_pin_prev_q <= rst_pin_s;
			expanded_mode_q <= expanded;
			if (rst_pin_rise)
			begin
				mode_q <= strap_mode;
				flash_map_enable_bit_q <= strap_flash;
			end
		end
	end

	assign {mode_select_bit_c_q, mode_select_bit_b_q, mode_select_bit_a_q} = mode_q;

	////////////////////////////////////////////////////////////////////////////
	// spi drive table, {oe, out} per role and instance
	logic [1:0] ss_drv [3];
	logic [1:0] sck_drv [3];
	logic [1:0] mosi_drv [3];
	logic [1:0] miso_drv [3];

	genvar n;
	for (n = 0; n < 3; n++) begin : g_spi
		// ss drives as master with its own enable
		assign ss_drv[n] = {spi_master[n] & spi_ss_oe[n], spi_ss_out[n]};
		assign sck_drv[n] = {spi_master[n], spi_sck_out[n]};
		assign mosi_drv[n] = {spi_master[n], spi_mosi_out[n]};
		assign miso_drv[n] = {~spi_master[n], spi_miso_out[n]};
	end

	logic spi2_h; // spi2 routed to h7..4
	logic spi2_p; // spi2 routed to p7..4
	assign spi2_h = spi_enable[2] & ~spi2_on_port_p;
	assign spi2_p = spi_enable[2] & spi2_on_port_p;

	////////////////////////////////////////////////////////////////////////////
	// pin drive: gpio first, later functions override
	logic [7:0] e_o, e_oe, h_o, h_oe, j_o, j_oe; // next pin drive
	logic [7:0] k_o, k_oe, m_o, m_oe, p_o, p_oe; // next pin drive

	// port e
	always_comb
	begin
		e_o = gpio_e_out;
		e_oe = gpio_e_dir;
		e_oe[pfm_pkg::E_IRQ] = 1'b0;
		e_oe[pfm_pkg::E_NMI] = 1'b0;
		if (queue_track_en)
			{e_oe[pfm_pkg::E_MODE_A], e_o[pfm_pkg::E_MODE_A]} = {1'b1, queue_track_out_0};
		if (bus_clock_out_en)
			{e_oe[pfm_pkg::E_BUSCLK], e_o[pfm_pkg::E_BUSCLK]} = {1'b1, bus_clock_level};
		if (expanded)
		begin
			// tagging turns the strobe pin into an input
			if (tag_enable)
				e_oe[pfm_pkg::E_STROBE] = 1'b0;
			else
				{e_oe[pfm_pkg::E_STROBE], e_o[pfm_pkg::E_STROBE]} = {1'b1, low_byte_strobe_n};
			{e_oe[pfm_pkg::E_RW], e_o[pfm_pkg::E_RW]} = {1'b1, bus_read_write};
		end
	end

	// port h: spi1 low nibble, spi2 high nibble
	always_comb
	begin
		h_o = gpio_h_out;
		h_oe = gpio_h_dir;
		if (spi_enable[1])
		begin
			{h_oe[pfm_pkg::H_SS], h_o[pfm_pkg::H_SS]} = ss_drv[1];
			{h_oe[pfm_pkg::H_SCK], h_o[pfm_pkg::H_SCK]} = sck_drv[1];
			{h_oe[pfm_pkg::H_MOSI], h_o[pfm_pkg::H_MOSI]} = mosi_drv[1];
			{h_oe[pfm_pkg::H_MISO], h_o[pfm_pkg::H_MISO]} = miso_drv[1];
		end
		if (spi2_h)
		begin
			{h_oe[4+pfm_pkg::H_SS], h_o[4+pfm_pkg::H_SS]} = ss_drv[2];
			{h_oe[4+pfm_pkg::H_SCK], h_o[4+pfm_pkg::H_SCK]} = sck_drv[2];
			{h_oe[4+pfm_pkg::H_MOSI], h_o[4+pfm_pkg::H_MOSI]} = mosi_drv[2];
			{h_oe[4+pfm_pkg::H_MISO], h_o[4+pfm_pkg::H_MISO]} = miso_drv[2];
		end
	end

	// port j: i2c open drain, can4 overrides it
	always_comb
	begin
		j_o = gpio_j_out;
		j_oe = gpio_j_dir;
		if (i2c_enable)
		begin
			{j_oe[pfm_pkg::J_TX], j_o[pfm_pkg::J_TX]} = {~i2c_scl_out, 1'b0};
			{j_oe[pfm_pkg::J_RX], j_o[pfm_pkg::J_RX]} = {~i2c_sda_out, 1'b0};
		end
		if (can4_route == pfm_pkg::CAN4_J76)
		begin
			{j_oe[pfm_pkg::J_TX], j_o[pfm_pkg::J_TX]} = {1'b1, can4_transmit_pin};
			j_oe[pfm_pkg::J_RX] = 1'b0;
		end
	end

	// port k: chip select and page address on the external bus
	always_comb
	begin
		k_o = gpio_k_out;
		k_oe = gpio_k_dir;
		if (expanded)
		begin
			{k_oe[pfm_pkg::K_CHIP_SEL], k_o[pfm_pkg::K_CHIP_SEL]} = {1'b1, emulation_chip_select_n};
			k_o[pfm_pkg::PAGE_W-1:0] = page_address_out;
			k_oe[pfm_pkg::PAGE_W-1:0] = '1;
		end
	end

	// port m: can0, then can4, then spi0 in rising priority
	always_comb
	begin
		m_o = gpio_m_out;
		m_oe = gpio_m_dir;
		unique case (can0_route)
			pfm_pkg::CAN0_M10: {m_oe[1:0], m_o[1:0]} = {2'b10, can0_transmit_pin, 1'b0};
			pfm_pkg::CAN0_M32: {m_oe[3:2], m_o[3:2]} = {2'b10, can0_transmit_pin, 1'b0};
			pfm_pkg::CAN0_M54: {m_oe[5:4], m_o[5:4]} = {2'b10, can0_transmit_pin, 1'b0};
			default: ;
		endcase
		unique case (can4_route)
			pfm_pkg::CAN4_M54: {m_oe[5:4], m_o[5:4]} = {2'b10, can4_transmit_pin, 1'b0};
			pfm_pkg::CAN4_M76: {m_oe[7:6], m_o[7:6]} = {2'b10, can4_transmit_pin, 1'b0};
			default: ;
		endcase
		if (spi_enable[0])
		begin
			{m_oe[pfm_pkg::M_SCK], m_o[pfm_pkg::M_SCK]} = sck_drv[0];
			{m_oe[pfm_pkg::M_MOSI], m_o[pfm_pkg::M_MOSI]} = mosi_drv[0];
			{m_oe[pfm_pkg::M_SS], m_o[pfm_pkg::M_SS]} = ss_drv[0];
			{m_oe[pfm_pkg::M_MISO], m_o[pfm_pkg::M_MISO]} = miso_drv[0];
		end
	end

	// port p: pwm7..4, spi2 overrides
	always_comb
	begin
		p_o = gpio_p_out;
		p_oe = gpio_p_dir;
		for (int c = 0; c < 4; c++)
		begin
			if (pwm_enable[c])
				{p_oe[pfm_pkg::PWM_P_LSB+c], p_o[pfm_pkg::PWM_P_LSB+c]} = {1'b1, pwm_out[c]};
		end
		if (spi2_p)
		begin
			{p_oe[pfm_pkg::P_SCK], p_o[pfm_pkg::P_SCK]} = sck_drv[2];
			{p_oe[pfm_pkg::P_SS], p_o[pfm_pkg::P_SS]} = ss_drv[2];
			{p_oe[pfm_pkg::P_MOSI], p_o[pfm_pkg::P_MOSI]} = mosi_drv[2];
			{p_oe[pfm_pkg::P_MISO], p_o[pfm_pkg::P_MISO]} = miso_drv[2];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pin levels back to the peripherals
	logic [3:0] spi0_i, spi1_i, spi2_i; // {ss, sck, mosi, miso}
	logic can0_rx, can4_rx; // selected receive pins

	assign spi0_i = {m_s[pfm_pkg::M_SS], m_s[pfm_pkg::M_SCK], m_s[pfm_pkg::M_MOSI], m_s[pfm_pkg::M_MISO]};
	assign spi1_i = h_s[3:0];
	assign spi2_i = spi2_on_port_p ? {p_s[pfm_pkg::P_SS], p_s[pfm_pkg::P_SCK], p_s[pfm_pkg::P_MOSI],
		p_s[pfm_pkg::P_MISO]} : h_s[7:4];

	// unrouted receiver reads recessive
	assign can0_rx = (can0_route == pfm_pkg::CAN0_M10) ? m_s[0]
		: (can0_route == pfm_pkg::CAN0_M32) ? m_s[2]
		: (can0_route == pfm_pkg::CAN0_M54) ? m_s[4] : 1'b1;
	assign can4_rx = (can4_route == pfm_pkg::CAN4_J76) ? j_s[pfm_pkg::J_RX]
		: (can4_route == pfm_pkg::CAN4_M54) ? m_s[4]
		: (can4_route == pfm_pkg::CAN4_M76) ? m_s[6] : 1'b1;

	////////////////////////////////////////////////////////////////////////////
	// key wakeup
	logic [19:0] wake_raw, wake_sync; // {h7..0, j7..0, p7..4}
	logic [19:0] wake_en; // j bits without a wake function masked
	logic wake_keys; // bare-level wake from the key inputs

	assign wake_raw = {port_h_in, port_j_in, port_p_in[7:4]};
	assign wake_sync = {h_s, j_s, p_s[7:4]};
	assign wake_en = key_wake_enable & {8'hff, pfm_pkg::J_WAKE_MASK, 4'hf};

	pfm_wake_detect #(
		.WIDTH(pfm_pkg::WAKE_W)
	) u_wake (
		.clock(clock),
		.reset_n(reset_n),
		.pin_raw(wake_raw),
		.pin_sync(wake_sync),
		.enable(wake_en),
		.rising(key_wake_rising),
		.clear(key_wake_clear),
		.flags_q(key_wake_flags_q),
		.wake_async(wake_keys)
	);

	// stopped clock: keys or an irq pin low
	assign wake_async = wake_keys | ~port_e_in[pfm_pkg::E_IRQ] | ~port_e_in[pfm_pkg::E_NMI];

	////////////////////////////////////////////////////////////////////////////
	// registered outputs
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			{port_e_out_q, port_e_oe_q, port_h_out_q, port_h_oe_q} <= '0;
			{port_j_out_q, port_j_oe_q, port_k_out_q, port_k_oe_q} <= '0;
			{port_m_out_q, port_m_oe_q, port_p_out_q, port_p_oe_q} <= '0;
			{spi_ss_in_q, spi_sck_in_q, spi_mosi_in_q, spi_miso_in_q} <= '0;
			{can0_receive_pin_q, can4_receive_pin_q} <= 2'h3;
			{i2c_scl_in_q, i2c_sda_in_q} <= 2'h3;
			tag_low_half_n_q <= 1'b1;
			{irq_request_q, nonmaskable_irq_q, key_wake_irq_q} <= '0;
		end
		else
		begin
			{port_e_out_q, port_e_oe_q, port_h_out_q, port_h_oe_q} <= {e_o, e_oe, h_o, h_oe};
			{port_j_out_q, port_j_oe_q, port_k_out_q, port_k_oe_q} <= {j_o, j_oe, k_o, k_oe};
			{port_m_out_q, port_m_oe_q, port_p_out_q, port_p_oe_q} <= {m_o, m_oe, p_o, p_oe};
			{spi_ss_in_q, spi_sck_in_q, spi_mosi_in_q, spi_miso_in_q} <=
				{spi2_i[3], spi1_i[3], spi0_i[3], spi2_i[2], spi1_i[2], spi0_i[2],
				spi2_i[1], spi1_i[1], spi0_i[1], spi2_i[0], spi1_i[0], spi0_i[0]};
			{can0_receive_pin_q, can4_receive_pin_q} <= {can0_rx, can4_rx};
			// a disabled bus reads idle high
			i2c_scl_in_q <= ~i2c_enable | j_s[pfm_pkg::J_TX];
			i2c_sda_in_q <= ~i2c_enable | j_s[pfm_pkg::J_RX];
			// low on the strobe pin tags the low half
			tag_low_half_n_q <= ~(expanded & tag_enable) | e_s[pfm_pkg::E_STROBE];
			irq_request_q <= ~e_s[pfm_pkg::E_IRQ];
			nonmaskable_irq_q <= ~e_s[pfm_pkg::E_NMI];
			key_wake_irq_q <= |key_wake_flags_q;
		end
	end

	assign gpio_in_q = pin_s2_q[47:0];

endmodule : pfm_port_mux

/* pfm_port_mux_asserts.sv */
// checker bound to the pin mux top.
// assumes one bus clock domain and a synchronous active low reset.
`timescale 1ns/1ps
module pfm_port_mux_asserts (
	input logic clock,
	input logic reset_n,
	input logic reset_pin_n,
	input logic mode_select_pin_c,
	input logic [7:0] port_e_in,
	input logic [7:0] port_k_in,
	input logic [7:0] port_e_out_q,
	input logic [7:0] port_e_oe_q,
	input logic [7:0] port_k_out_q,
	input logic [7:0] port_k_oe_q,
	input logic [7:0] port_h_oe_q,
	input logic mode_select_bit_a_q,
	input logic mode_select_bit_b_q,
	input logic mode_select_bit_c_q,
	input logic flash_map_enable_bit_q,
	input logic expanded_mode_q,
	input logic bus_read_write,
	input logic emulation_chip_select_n,
	input logic [5:0] page_address_out,
	input logic [2:0] spi_enable,
	input logic [2:0] spi_master,
	input logic irq_request_q,
	input logic [19:0] key_wake_clear,
	input logic [19:0] key_wake_flags_q
);
	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	// steady straps at reset pin rise land in mode and flash
	a_strap_latch: assert property ($rose(reset_pin_n) ##0 (reset_pin_n && $stable({mode_select_pin_c, port_e_in[6:5],
		port_k_in[7]}))[*6] |=> {mode_select_bit_c_q, mode_select_bit_b_q, mode_select_bit_a_q}
		== {mode_select_pin_c, port_e_in[6:5]}
		&& (!mode_select_pin_c || !port_e_in[5] || flash_map_enable_bit_q == port_k_in[7]))
		else $error("strap latch wrong");
	a_irq_follows: assert property ((!port_e_in[1])[*3] |=> irq_request_q)
		else $error("irq request missing");
	a_e_input_only: assert property (port_e_oe_q[1:0] == 2'h0)
		else $error("input pin driven");
	a_rw_drive: assert property ($past(reset_n) && $past(expanded_mode_q)
		|-> port_e_oe_q[2] && port_e_out_q[2] == $past(bus_read_write))
		else $error("read write pin wrong");
	a_page_out: assert property ($past(reset_n) && $past(expanded_mode_q) |-> (port_k_oe_q | 8'h40) == 8'hff
		&& port_k_out_q[5:0] == $past(page_address_out) && port_k_out_q[7] == $past(emulation_chip_select_n))
		else $error("page or chip select wrong");
	a_spi1_dir: assert property ($past(reset_n) && $past(spi_enable[1])
		|-> port_h_oe_q[1] == $past(spi_master[1]) && port_h_oe_q[0] != $past(spi_master[1]))
		else $error("spi data pin direction wrong");
	a_flash_off: assert property (!mode_select_bit_c_q && (mode_select_bit_a_q || mode_select_bit_b_q)
		|-> !flash_map_enable_bit_q)
		else $error("flash map set in expanded test mode");
	a_flash_on: assert property (!mode_select_bit_a_q && (mode_select_bit_c_q || !mode_select_bit_b_q)
		|-> flash_map_enable_bit_q)
		else $error("flash map clear in single chip mode");
	a_flag_sticky: assert property ($past(reset_n)
		|-> ($past(key_wake_flags_q) & ~$past(key_wake_clear) & ~key_wake_flags_q) == 20'h00000)
		else $error("wake flag lost");
	// main scenarios
	c_expanded: cover property (expanded_mode_q && !flash_map_enable_bit_q);
	c_irq: cover property (irq_request_q);
	c_wake: cover property (key_wake_flags_q[12]);
	c_spi: cover property (spi_enable[1] && spi_master[1]);
endmodule : pfm_port_mux_asserts
bind pfm_port_mux pfm_port_mux_asserts u_chk (.*);

/* pfm_board_model.sv */
// board side of ports e..p, e in the top byte.
// assumes a pull-up on each pin; board drives only where told.
`timescale 1ns/1ps
module pfm_board_model (
	input logic [47:0] dev_out,
	input logic [47:0] dev_oe,
	input logic [47:0] brd_drv,
	input logic [47:0] brd_val,
	output logic [47:0] pin
);
	// device, then board (e3 low tags), else pull-up
	assign pin = (dev_oe & dev_out) | (~dev_oe & brd_drv & brd_val) | (~dev_oe & ~brd_drv);
endmodule : pfm_board_model

/* pfm_port_mux_tb.sv */
// testbench for the port pin function multiplexer.
// assumes the board model resolves every pin from device and board drive.
`timescale 1ns/1ps
module pfm_port_mux_tb;
	typedef struct packed {
		logic [2:0] en, mst, sck, mosi, miso, ss, ssoe;
		logic [7:0] gdir, gout, oe, drv;
	} pfm_row_type;
	logic clock = 1'b0, reset_n = 1'b0, reset_pin_n = 1'b0, mode_select_pin_c = 1'b0;
	wire logic [7:0] port_e_in, port_h_in, port_j_in, port_k_in, port_m_in, port_p_in;
	logic [7:0] port_e_out_q, port_e_oe_q, port_h_out_q, port_h_oe_q, port_j_out_q, port_j_oe_q, port_k_out_q,
		port_k_oe_q, port_m_out_q, port_m_oe_q, port_p_out_q, port_p_oe_q;
	logic [7:0] gpio_e_out = 8'h00, gpio_e_dir = 8'h00, gpio_h_out = 8'h00, gpio_h_dir = 8'h00, gpio_j_out = 8'h00,
		gpio_j_dir = 8'h00, gpio_k_out = 8'h00, gpio_k_dir = 8'h00, gpio_m_out = 8'h00, gpio_m_dir = 8'h00,
		gpio_p_out = 8'h00, gpio_p_dir = 8'h00;
	logic [47:0] gpio_in_q, brd_drv = 48'h0, brd_val = 48'h0;
	logic mode_select_bit_a_q, mode_select_bit_b_q, mode_select_bit_c_q, flash_map_enable_bit_q, expanded_mode_q,
		tag_low_half_n_q, irq_request_q, nonmaskable_irq_q, key_wake_irq_q, wake_async, can0_receive_pin_q,
		can4_receive_pin_q, i2c_scl_in_q, i2c_sda_in_q;
	logic queue_track_en = 1'b0, queue_track_out_0 = 1'b0, bus_clock_out_en = 1'b0, bus_clock_level = 1'b0,
		tag_enable = 1'b0, low_byte_strobe_n = 1'b1, bus_read_write = 1'b0, emulation_chip_select_n = 1'b1,
		spi2_on_port_p = 1'b0, can0_transmit_pin = 1'b0, can4_transmit_pin = 1'b0, i2c_enable = 1'b0,
		i2c_scl_out = 1'b1, i2c_sda_out = 1'b1;
	logic [5:0] page_address_out = 6'h00;
	logic [19:0] key_wake_enable = 20'h0, key_wake_rising = 20'h0, key_wake_clear = 20'h0, key_wake_flags_q;
	logic [2:0] spi_enable = 3'h0, spi_master = 3'h0, spi_sck_out = 3'h0, spi_ss_out = 3'h0, spi_ss_oe = 3'h0,
		spi_mosi_out = 3'h0, spi_miso_out = 3'h0, spi_sck_in_q, spi_ss_in_q, spi_mosi_in_q, spi_miso_in_q;
	logic [1:0] can0_route = 2'h0, can4_route = 2'h0;
	logic [3:0] pwm_enable = 4'h0, pwm_out = 4'h0;
	int bad_count = 0, total_checks = 0;
	// port h rows: spi and gpio in, expected oe and drive
	pfm_row_type rows [4] = '{
		'{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 8'hf0, 8'ha5, 8'hf0, 8'ha0},
		'{3'h2, 3'h2, 3'h2, 3'h2, 3'h0, 3'h0, 3'h2, 8'h00, 8'h00, 8'h0e, 8'h06},
		'{3'h2, 3'h0, 3'h0, 3'h0, 3'h2, 3'h0, 3'h0, 8'hff, 8'h00, 8'hf1, 8'h01},
		'{3'h4, 3'h4, 3'h4, 3'h4, 3'h0, 3'h4, 3'h4, 8'h00, 8'h00, 8'he0, 8'he0}};
	////////////////////////////////////////////////////////////////////////////////
	pfm_board_model board (
		.dev_out({port_e_out_q, port_h_out_q, port_j_out_q, port_k_out_q, port_m_out_q, port_p_out_q}),
		.dev_oe({port_e_oe_q, port_h_oe_q, port_j_oe_q, port_k_oe_q, port_m_oe_q, port_p_oe_q}),
		.brd_drv(brd_drv),
		.brd_val(brd_val),
		.pin({port_e_in, port_h_in, port_j_in, port_k_in, port_m_in, port_p_in}));
	pfm_port_mux dut (.*);
	initial
	begin
		forever #4 clock = ~clock;
	end
	task automatic step(input int n);
		repeat (n) @(negedge clock);
	endtask : step
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string name);
		total_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : summarize
	// reset with straps, then reset pin rise
	task automatic strap(input logic [2:0] m, input logic k7);
		reset_n = 1'b0;
		reset_pin_n = 1'b0;
		mode_select_pin_c = m[2];
		brd_drv[46:45] = 2'h3;
		brd_val[46:45] = m[1:0];
		brd_drv[23] = 1'b1;
		brd_val[23] = k7;
		emulation_chip_select_n = k7;
		step(2);
		reset_n = 1'b1;
		step(1);
		reset_pin_n = 1'b1;
		step(8);
		chk({mode_select_bit_c_q, mode_select_bit_b_q, mode_select_bit_a_q}, m, "mode");
		chk(flash_map_enable_bit_q, m inside {3'h1, 3'h2, 3'h3} ? 1'b0 : m[2] & m[0] ? k7 : 1'b1, "flash");
		chk(expanded_mode_q, m inside {3'h1, 3'h2, 3'h3, 3'h5, 3'h7}, "expanded");
	endtask : strap
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		step(16);
		reset_n = 1'b1;
		step(1);
		chk({irq_request_q, nonmaskable_irq_q}, 2'h0, "reset_irq");
		step(2);
		chk({port_e_oe_q, port_k_oe_q, flash_map_enable_bit_q, can0_receive_pin_q}, 18'h3, "reset");
		$display("reset test done");
		foreach (rows[i])
		begin
			{spi_enable, spi_master, spi_sck_out, spi_mosi_out, spi_miso_out, spi_ss_out, spi_ss_oe, gpio_h_dir,
				gpio_h_out} = rows[i][52:16];
			step(2);
			chk(port_h_oe_q, rows[i].oe, "h_oe");
			chk(port_h_out_q & port_h_oe_q, rows[i].drv, "h_out");
		end
		pwm_enable = 4'hf;
		pwm_out = 4'h5;
		step(2);
		chk({port_p_oe_q, port_p_out_q & port_p_oe_q}, 16'hf050, "pwm");
		spi2_on_port_p = 1'b1;
		step(2);
		chk({port_p_oe_q, port_p_out_q & port_p_oe_q, port_h_oe_q}, 24'he0e000, "spi2_p");
		spi_enable = 3'h0;
		$display("spi and pwm test done");
		for (int i = 0; i < 10; i++)
			strap(i < 8 ? 3'(i) : 3'(2 * i - 11), i < 8);
		$display("strap test done");
		// mode 7 now: expanded bus pins
		bus_read_write = 1'b1;
		low_byte_strobe_n = 1'b0;
		page_address_out = 6'h2a;
		emulation_chip_select_n = 1'b0;
		step(2);
		chk({port_e_oe_q, port_e_out_q[3:2]}, 10'h031, "e_bus");
		chk({port_k_oe_q, port_k_out_q & port_k_oe_q}, 16'hbf2a, "k_bus");
		tag_enable = 1'b1;
		brd_drv[43] = 1'b1;
		step(4);
		chk({tag_low_half_n_q, port_e_oe_q[3]}, 2'h0, "tag");
		queue_track_en = 1'b1;
		queue_track_out_0 = 1'b1;
		bus_clock_out_en = 1'b1;
		bus_clock_level = 1'b1;
		step(2);
		chk(port_e_oe_q[5:4] & port_e_out_q[5:4], 2'h3, "e_qt_clk");
		queue_track_en = 1'b0;
		tag_enable = 1'b0;
		brd_drv[43] = 1'b0;
		strap(3'h4, 1'b1);
		chk({port_k_oe_q, port_e_oe_q}, 16'h0010, "single");
		$display("bus test done");
		brd_drv[41:40] = 2'h3;
		step(1);
		chk(wake_async, 1'b1, "wake_async");
		step(4);
		chk({irq_request_q, nonmaskable_irq_q}, 2'h3, "irq");
		brd_drv[41:40] = 2'h0;
		step(5);
		chk({irq_request_q, nonmaskable_irq_q, wake_async}, 3'h0, "irq_off");
		// h0 enabled, j2 has no wake function
		key_wake_enable = 20'h01040;
		brd_drv[32] = 1'b1;
		brd_drv[26] = 1'b1;
		step(6);
		chk({key_wake_flags_q, key_wake_irq_q}, 21'h002001, "wake");
		key_wake_clear = 20'hfffff;
		step(1);
		key_wake_clear = 20'h00000;
		step(2);
		chk({key_wake_flags_q, key_wake_irq_q}, 21'h0, "wake_clr");
		$display("interrupt test done");
		for (int r = 1; r < 4; r++)
		begin
			can0_route = 2'(r);
			brd_drv[2 * r + 6] = 1'b1;
			step(4);
			chk({port_m_oe_q, can0_receive_pin_q}, {8'h01 << (2 * r - 1), 1'b0}, "can0");
			brd_drv[2 * r + 6] = 1'b0;
		end
		can0_route = 2'h0;
		can4_route = 2'h1;
		brd_drv[30] = 1'b1;
		step(4);
		chk({port_j_oe_q, can4_receive_pin_q}, {8'h80, 1'b0}, "can4");
		$display("can test done");
		summarize;
	end
	// watchdog; the run needs under a thousand cycles
	initial
	begin
		step(20000);
		bad_count++;
		summarize;
	end
endmodule : pfm_port_mux_tb
